// ==== logic/lldh_pkg.sv ====
// Package of constants shared by the LIN low-detect and header control block.
package lldh_pkg;
   // Reset value of the response frame control register, all zeros.
   localparam logic [7:0] LLDH_RFC_RESET = 8'h00;
   // Number of implemented bits in the response frame control register.
   localparam int LLDH_RFC_BITS = 2;
   // Default baud divider: peripheral clocks per bit period.
   localparam int LLDH_BAUD_DIV = 5208;
   // Bits in one transmitted data byte.
   localparam logic [3:0] LLDH_DATA_BITS = 4'h8;
   // Minimum break low length in bits, added to the four-bit setting.
   localparam logic [4:0] LLDH_BREAK_LOW_BASE = 5'h0d;
   // Minimum delimiter length in bits, added to the two-bit setting.
   localparam logic [2:0] LLDH_DELIM_BASE = 3'h1;
   // Interbyte space in bit periods.
   localparam logic [3:0] LLDH_INTERBYTE_BITS = 4'h1;
   // Transmit sequencer states.
   typedef enum logic [2:0] {LLDH_IDLE, LLDH_BRK_LOW, LLDH_BRK_HIGH, LLDH_START, LLDH_DATA, LLDH_STOP,
      LLDH_SPACE} lldh_state_type;
endpackage

// ==== logic/lldh_fifo.sv ====
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module lldh_fifo import lldh_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic [WIDTH-1:0] inData, // Write data.
   input wire logic inValid, // Write request.
   output logic inReady, // Space available.
   output logic [WIDTH-1:0] outData, // Head word.
   output logic outValid, // Head word present.
   input wire logic outReady // Head word taken.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
   logic [AW-1:0] wrPtr; // Write index.
   logic [AW-1:0] rdPtr; // Read index.
   logic [AW:0] count; // Fill level.
   logic doWr; // Word accepted.
   logic doRd; // Word drained.

   // Handshakes qualify with the honest full and empty flags.
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];

   // Storage writes need no reset since the fill level guards reads.
   always_ff @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end

   // Pointers and fill level; pointers wrap at the depth.
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (doRd) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         if (doWr && !doRd) begin
            count <= count + 1'b1;
         end else if (doRd && !doWr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ==== logic/lldh_top.sv ====
// LIN low-level detection, interrupt aggregation and break/response transmit sequencer.
//
// Function
// - Falling receive edge while enabled sets low flag.
// - Enabling while line low sets flag immediately.
// - Suppression setting blocks low-detect interrupt requests.
// - Flags clear only by writing zero.
// - No new request while low flag set.
// - Aggregated sources: no request while any set.
// - Four-bit break low, two-bit delimiter length.
// - Control register resets zero, bits 7:2 read zero.
// - Send byte then interbyte space, abort on error.
`timescale 1ns/1ns
module lldh_top import lldh_pkg::*; #(
   parameter int BAUD_DIV = LLDH_BAUD_DIV, // Clocks per LIN bit.
   parameter int FIFO_DEPTH = 8 // Transmit data buffer depth.
) (
   input wire logic clk, // 100 MHz peripheral clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic busRxPin, // LIN receive pin from transceiver.
   output logic busTxPin, // LIN transmit pin to transceiver.
   input wire logic lowDetectEnable, // Low-level detection enable.
   input wire logic lowDetectIrqOff, // Suppress low-detect interrupt when 1.
   input wire logic lowDetectClear, // Pulse: software writes 0 to the low flag.
   output logic lowDetectFlag, // Sticky low-detect flag.
   output logic lowDetectIrq, // One-cycle low-detect request.
   input wire logic [3:0] breakLowLength, // Break low setting.
   input wire logic [1:0] breakHighDelimiterLength, // Delimiter setting.
   input wire logic [3:0] responseDataLength, // Data bytes per response.
   input wire logic frameStart, // Pulse: start a header and response.
   input wire logic txError, // Error abort request.
   input wire logic [7:0] txData, // Data byte to buffer.
   input wire logic txValid, // Data byte offered.
   output logic txReady, // Buffer can take a byte.
   input wire logic [7:0] rfcWriteData, // Response frame control write data.
   input wire logic rfcWrite, // Response frame control write strobe.
   output logic [7:0] rfcReadData, // Response frame control read value.
   input wire logic [1:0] statusClear, // Pulse per bit: write 0 to status flag.
   output logic [1:0] linStatus, // Bit0 frame done, bit1 error.
   output logic linIrq, // One-cycle aggregated channel request.
   output logic txBusy // Sequencer active.
);
   logic rxMeta; // First synchroniser stage.
   logic rxSync; // Second synchroniser stage.
   logic rxPrev; // Previous synchronised level.
   logic enablePrev; // Previous enable level.
   logic lowEvent; // Low condition seen this cycle.
   logic [1:0] rfc; // Implemented control bits.
   logic [$clog2(BAUD_DIV)-1:0] baudCnt; // Bit period divider.
   logic bitTick; // One-cycle enable per LIN bit.
   lldh_state_type state; // Sequencer state.
   logic [4:0] bitCnt; // Bits left in the current phase.
   logic [3:0] byteCnt; // Bytes sent so far.
   logic [7:0] shiftReg; // Outgoing byte.
   logic [7:0] fifoData; // Buffer head.
   logic fifoValid; // Buffer holds a byte.
   logic fifoTake; // Sequencer takes the head.
   logic fifoReady; // Buffer write ready.
   logic doneEvent; // Frame completed this cycle.
   logic errEvent; // Frame aborted this cycle.
   logic fifoWrite; // Port handshake completed this cycle.
   logic byteDue; // Sequencer wants the next byte now.

   // The receive pin crosses in through two flops before anything looks at it.
   always_ff @(posedge clk) begin
      if (srst) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
         rxPrev <= 1'b1;
         enablePrev <= 1'b0;
      end else begin
         rxMeta <= busRxPin;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
         enablePrev <= lowDetectEnable;
      end
   end

   // Falling edge while enabled, or the enable rising with the line already low.
   assign lowEvent = lowDetectEnable && ((rxPrev && !rxSync) || (!enablePrev && !rxSync));

   // Sticky low flag; a new event beats a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (srst) begin
         lowDetectFlag <= 1'b0;
      end else if (lowEvent) begin
         lowDetectFlag <= 1'b1;
      end else if (lowDetectClear) begin
         lowDetectFlag <= 1'b0;
      end
   end

   // Own request line; no repeat while the flag is still up, none when suppressed.
   always_ff @(posedge clk) begin
      if (srst) begin
         lowDetectIrq <= 1'b0;
      end else begin
         lowDetectIrq <= lowEvent && !lowDetectFlag && !lowDetectIrqOff;
      end
   end

   // Control register: only two bits exist, the rest read as zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         rfc <= LLDH_RFC_RESET[LLDH_RFC_BITS-1:0];
      end else if (rfcWrite) begin
         rfc <= rfcWriteData[LLDH_RFC_BITS-1:0];
      end
   end

   // Registered read keeps the output straight from a flop.
   always_ff @(posedge clk) begin
      if (srst) begin
         rfcReadData <= LLDH_RFC_RESET;
      end else begin
         rfcReadData <= {6'h00, rfc};
      end
   end

   // Baud divider gives one enable per bit; it idles at zero between frames and while stalled for data,
   // so a late byte still gets a full start bit.
   always_ff @(posedge clk) begin
      if (srst || state == LLDH_IDLE || state == LLDH_START) begin
         baudCnt <= '0;
      end else if (baudCnt == ($clog2(BAUD_DIV))'(BAUD_DIV-1)) begin
         baudCnt <= '0;
      end else begin
         baudCnt <= baudCnt + 1'b1;
      end
   end
   assign bitTick = (state != LLDH_IDLE) && (baudCnt == ($clog2(BAUD_DIV))'(BAUD_DIV-1));

   // Transmit data buffer; the sequencer stalls on an empty buffer.
   lldh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) lldh_fifo_inst (
      .clk(clk),
      .srst(srst),
      .inData(txData),
      .inValid(fifoWrite),
      .inReady(fifoReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoTake)
   );
   // A byte is written only when the port handshake completes, never while the port shows not ready.
   assign fifoWrite = txValid && txReady;

   // The next byte is due as the delimiter or an interbyte space ends, so no extra idle bit creeps in.
   assign byteDue = (state == LLDH_START) ||
      (bitTick && state == LLDH_BRK_HIGH && bitCnt == 5'h01 && responseDataLength != 4'h0) ||
      (bitTick && state == LLDH_SPACE && bitCnt == 5'h00 && byteCnt != responseDataLength);
   assign fifoTake = byteDue && fifoValid && !txError;

   // Ready is registered so the port comes from a flop; it may lag one cycle, which is conservative.
   always_ff @(posedge clk) begin
      if (srst) begin
         txReady <= 1'b0;
      end else begin
         txReady <= fifoReady && !(txValid && txReady);
      end
   end

   // Sequencer: break low, delimiter, then byte plus interbyte space per data byte.
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= LLDH_IDLE;
         bitCnt <= '0;
         byteCnt <= '0;
         shiftReg <= '0;
         busTxPin <= 1'b1;
      end else if (txError && state != LLDH_IDLE) begin
         state <= LLDH_IDLE;
         busTxPin <= 1'b1;
      end else begin
         unique case (state)
            LLDH_IDLE: begin
               busTxPin <= 1'b1;
               if (frameStart) begin
                  state <= LLDH_BRK_LOW;
                  bitCnt <= LLDH_BREAK_LOW_BASE + {1'b0, breakLowLength};
                  byteCnt <= '0;
                  busTxPin <= 1'b0;
               end
            end
            LLDH_BRK_LOW: begin
               if (bitTick) begin
                  if (bitCnt == 5'h01) begin
                     state <= LLDH_BRK_HIGH;
                     bitCnt <= {2'b00, LLDH_DELIM_BASE + {1'b0, breakHighDelimiterLength}};
                     busTxPin <= 1'b1;
                  end else begin
                     bitCnt <= bitCnt - 1'b1;
                  end
               end
            end
            LLDH_BRK_HIGH: begin
               if (bitTick) begin
                  if (bitCnt == 5'h01) begin
                     state <= (responseDataLength == 4'h0) ? LLDH_IDLE : LLDH_START;
                     bitCnt <= '0;
                  end else begin
                     bitCnt <= bitCnt - 1'b1;
                  end
               end
            end
            LLDH_START: begin
               // Stalled on an empty buffer; the line stays recessive until a byte arrives.
               busTxPin <= 1'b1;
            end
            LLDH_DATA: begin
               if (bitTick) begin
                  busTxPin <= shiftReg[0];
                  shiftReg <= {1'b0, shiftReg[7:1]};
                  if (bitCnt == 5'h01) begin
                     state <= LLDH_STOP;
                  end
                  bitCnt <= bitCnt - 1'b1;
               end
            end
            LLDH_STOP: begin
               if (bitTick) begin
                  busTxPin <= 1'b1;
                  bitCnt <= {1'b0, LLDH_INTERBYTE_BITS};
                  byteCnt <= byteCnt + 1'b1;
                  state <= LLDH_SPACE;
               end
            end
            LLDH_SPACE: begin
               if (bitTick) begin
                  if (bitCnt == 5'h00) begin
                     state <= (byteCnt == responseDataLength) ? LLDH_IDLE : LLDH_START;
                  end else begin
                     bitCnt <= bitCnt - 1'b1;
                  end
               end
            end
         endcase
         // Loading a byte overrides whatever the phase above chose and opens the start bit.
         if (fifoTake) begin
            shiftReg <= fifoData;
            busTxPin <= 1'b0;
            bitCnt <= {1'b0, LLDH_DATA_BITS};
            state <= LLDH_DATA;
         end
      end
   end

   // Completion and abort events for the channel status.
   assign doneEvent = (state == LLDH_SPACE) && bitTick && bitCnt == 5'h00 && byteCnt == responseDataLength;
   assign errEvent = txError && state != LLDH_IDLE;

   // Status flags: set wins over a software clear; writing 1 does nothing.
   always_ff @(posedge clk) begin
      if (srst) begin
         linStatus <= 2'b00;
      end else begin
         linStatus[0] <= doneEvent | (linStatus[0] & !statusClear[0]);
         linStatus[1] <= errEvent | (linStatus[1] & !statusClear[1]);
      end
   end

   // Aggregated request fires only when no source flag is already set.
   always_ff @(posedge clk) begin
      if (srst) begin
         linIrq <= 1'b0;
      end else begin
         linIrq <= (doneEvent || errEvent) && (linStatus == 2'b00);
      end
   end

   // Busy mirrors the sequencer from a flop.
   always_ff @(posedge clk) begin
      if (srst) begin
         txBusy <= 1'b0;
      end else begin
         txBusy <= (state != LLDH_IDLE) || frameStart;
      end
   end
endmodule

// ==== verif/lldh_properties.sv ====
// Concurrent checks on the ports of the low-detect and header control block.
`timescale 1ns/1ns
module lldh_checker (
   input wire logic clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic lowDetectIrqOff, // Suppression.
   input wire logic lowDetectClear, // Flag clear.
   input wire logic lowDetectFlag, // Low flag.
   input wire logic lowDetectIrq, // Low request.
   input wire logic frameStart, // Frame start.
   input wire logic txError, // Abort.
   input wire logic [7:0] rfcReadData, // Control readback.
   input wire logic [1:0] statusClear, // Status clear.
   input wire logic [1:0] linStatus, // Status flags.
   input wire logic linIrq, // Channel request.
   input wire logic busTxPin, // Transmit pin.
   input wire logic txBusy // Busy.
);
   // One clock domain, so one clocking and one reset for all checks.
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   off_blocks_irq_a: assert property (
      lowDetectIrqOff && $past(lowDetectIrqOff) |-> !lowDetectIrq) else $error("low request while suppressed");
   irq_new_flag_a: assert property (
      lowDetectIrq |-> lowDetectFlag && !$past(lowDetectFlag)) else $error("low request with flag already set");
   low_sticky_a: assert property (
      !$past(srst) && $past(lowDetectFlag) && !$past(lowDetectClear) |-> lowDetectFlag) else $error("low flag lost");
   status_sticky_a: assert property (
      !$past(srst) |-> ($past(linStatus) & ~$past(statusClear) & ~linStatus) == 2'h0) else $error("status lost");
   agg_irq_a: assert property (
      linIrq |-> $past(linStatus) == 2'h0 && linStatus != 2'h0) else $error("channel request while flag set");
   irq_pulse_a: assert property (
      (lowDetectIrq |=> !lowDetectIrq) and (linIrq |=> !linIrq)) else $error("request longer than a cycle");
   rfc_upper_a: assert property (
      rfcReadData[7:2] == 6'h00) else $error("control upper bits not zero");
   break_start_a: assert property (
      frameStart && !txBusy && !txError |=> !busTxPin && txBusy) else $error("break did not start");
   idle_high_a: assert property (
      !txBusy && !$past(txBusy) |-> busTxPin) else $error("pin low while idle");
endmodule
bind lldh_top lldh_checker lldh_checker_inst (.clk(clk), .srst(srst), .lowDetectIrqOff(lowDetectIrqOff),
   .lowDetectClear(lowDetectClear), .lowDetectFlag(lowDetectFlag), .lowDetectIrq(lowDetectIrq),
   .frameStart(frameStart), .txError(txError), .rfcReadData(rfcReadData), .statusClear(statusClear),
   .linStatus(linStatus), .linIrq(linIrq), .busTxPin(busTxPin), .txBusy(txBusy));

// ==== verif/lldh_bus_model.sv ====
// Behavioural transceiver and remote node on the far side of the bus.
`timescale 1ns/1ns
module lldh_bus_model (
   input wire logic busTxPin, // Transmit pin of the block.
   input wire logic holdLow, // A remote node drives dominant low.
   output logic busRxPin // Receive pin of the block.
);
   // The bus has a pull-up and any low driver wins, so the block hears its own bits.
   assign busRxPin = busTxPin & ~holdLow;
endmodule

// ==== verif/test_lldh_top.sv ====
// Self-checking bench for the low-detect and header control block.
`timescale 1ns/1ns
module test_lldh_top import lldh_pkg::*;;
   localparam int BD = 4; // Short bit period keeps the run brief.
   logic clk = 1'b0, srst = 1'b1, holdLow = 1'b0, busRxPin, busTxPin;
   logic lowDetectEnable = 1'b0, lowDetectIrqOff = 1'b0, lowDetectClear = 1'b0, lowDetectFlag, lowDetectIrq;
   logic [3:0] breakLowLength = 4'h2, responseDataLength = 4'h8;
   logic [1:0] breakHighDelimiterLength = 2'h3, statusClear = 2'h0, linStatus;
   logic frameStart = 1'b0, txError = 1'b0, txValid = 1'b0, txReady, rfcWrite = 1'b0, linIrq, txBusy;
   logic [7:0] txData = 8'h00, rfcWriteData = 8'h00, rfcReadData;
   int n_errors = 0, checked = 0, cycles = 0, lowIrqs = 0, linIrqs = 0, n;
   lldh_top #(.BAUD_DIV(BD)) lldh_top_inst (.clk(clk), .srst(srst), .busRxPin(busRxPin), .busTxPin(busTxPin),
      .lowDetectEnable(lowDetectEnable), .lowDetectIrqOff(lowDetectIrqOff), .lowDetectClear(lowDetectClear),
      .lowDetectFlag(lowDetectFlag), .lowDetectIrq(lowDetectIrq), .breakLowLength(breakLowLength),
      .breakHighDelimiterLength(breakHighDelimiterLength), .responseDataLength(responseDataLength),
      .frameStart(frameStart), .txError(txError), .txData(txData), .txValid(txValid), .txReady(txReady),
      .rfcWriteData(rfcWriteData), .rfcWrite(rfcWrite), .rfcReadData(rfcReadData), .statusClear(statusClear),
      .linStatus(linStatus), .linIrq(linIrq), .txBusy(txBusy));
   lldh_bus_model lldh_bus_model_inst (.busTxPin(busTxPin), .holdLow(holdLow), .busRxPin(busRxPin));
   initial begin
      forever #5 clk = ~clk;
   end
   // Requests are counted here, so a scenario can tell whether one came at all.
   always @(posedge clk) begin
      cycles++;
      if (lowDetectIrq === 1'b1) lowIrqs++;
      if (linIrq === 1'b1) linIrqs++;
      if (cycles == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Counts edges until the pin shows the given level; the bound stops a hang.
   task waitPin(input logic v, output int k);
      k = 0;
      while (busTxPin !== v && k < 300) begin
         @(posedge clk);
         k++;
      end
   endtask
   task pulseLow(input int irqs, input logic flag);
      holdLow <= 1'b1;
      tick(8);
      check("low flag", lowDetectFlag, flag);
      check("low requests", lowIrqs, irqs);
      holdLow <= 1'b0;
      tick(4);
   endtask
   task clearLow();
      lowDetectClear <= 1'b1;
      tick(1);
      lowDetectClear <= 1'b0;
      tick(3);
      check("low flag cleared", lowDetectFlag, 1'b0);
   endtask
   task t_low();
      lowDetectEnable <= 1'b1;
      tick(4);
      pulseLow(1, 1'b1);
      pulseLow(1, 1'b1);
      clearLow();
      lowDetectEnable <= 1'b0;
      holdLow <= 1'b1;
      tick(8);
      check("flag while disabled", lowDetectFlag, 1'b0);
      lowDetectEnable <= 1'b1;
      tick(4);
      check("enable while low", lowDetectFlag, 1'b1);
      check("enable request", lowIrqs, 2);
      holdLow <= 1'b0;
      lowDetectIrqOff <= 1'b1;
      clearLow();
      pulseLow(2, 1'b1);
      lowDetectEnable <= 1'b0;
      lowDetectIrqOff <= 1'b0;
      clearLow();
   endtask
   task t_rfc();
      rfcWriteData <= 8'hff;
      rfcWrite <= 1'b1;
      tick(1);
      rfcWrite <= 1'b0;
      tick(3);
      check("control readback", rfcReadData, 8'h03);
   endtask
   // Fills the buffer until it refuses, then sends all eight bytes and checks every bit on the pin.
   task t_frame();
      txValid <= 1'b1;
      txData <= 8'h3c;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (txReady === 1'b1 && n < 9) begin
            n++;
            txData <= 8'h3c ^ (8'(n) * 8'h25);
         end
      end
      txValid <= 1'b0;
      check("buffer depth", n, 8);
      frameStart <= 1'b1;
      tick(1);
      frameStart <= 1'b0;
      waitPin(1'b0, n);
      waitPin(1'b1, n);
      check("break low", n, (LLDH_BREAK_LOW_BASE + 2) * BD);
      waitPin(1'b0, n);
      check("delimiter", n, (LLDH_DELIM_BASE + 3) * BD);
      for (int b = 0; b < 8; b++) begin
         waitPin(1'b0, n);
         for (int j = 0; j < 11; j++) begin
            tick(j == 0 ? 2 : BD);
            check("bit", busTxPin,
               (j == 0) ? 1'b0 : (j > 8) ? 1'b1 : ((8'h3c ^ (8'(b) * 8'h25)) >> (j - 1)) & 8'h01);
         end
      end
      n = 0;
      while (linIrq !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      tick(1);
      check("frame done", linStatus, 2'h1);
      check("channel requests", linIrqs, 1);
   endtask
   task t_abort();
      responseDataLength <= 4'h2;
      frameStart <= 1'b1;
      tick(1);
      frameStart <= 1'b0;
      tick(10);
      txError <= 1'b1;
      tick(1);
      txError <= 1'b0;
      tick(6);
      check("busy after abort", txBusy, 1'b0);
      check("pin after abort", busTxPin, 1'b1);
      check("error status", linStatus, 2'h3);
      check("no second request", linIrqs, 1);
      statusClear <= 2'h3;
      tick(1);
      statusClear <= 2'h0;
      tick(3);
      check("status cleared", linStatus, 2'h0);
      // A header-only frame ends after break and delimiter and leaves the line recessive.
      responseDataLength <= 4'h0;
      frameStart <= 1'b1;
      tick(1);
      frameStart <= 1'b0;
      tick(80);
      check("header only", {txBusy, busTxPin}, 2'h1);
   endtask
   task wrap_up();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tick(4);
      srst <= 1'b0;
      tick(2);
      check("control reset", rfcReadData, LLDH_RFC_RESET);
      check("status reset", {linStatus, lowDetectFlag, busTxPin}, 4'h1);
      t_rfc();
      t_low();
      t_frame();
      t_abort();
      wrap_up();
   end
endmodule
